// ==== design/lhpmv_gain_decode.sv ====
// attenuation code to gain and mute decoder for one mixer path
`timescale 1ns/1ps
`default_nettype none

module lhpmv_gain_decode (
  // stored or pending attenuation code
  input wire lhpmv_pkg::lhpmv_code_t code,
  // decoded attenuation in tenths of a dB, and mute
  output lhpmv_pkg::lhpmv_gain_t atten_tenths,
  output logic mute
);
  import lhpmv_pkg::*;

  // irregular tail of the curve, codes 37 to 117, tenths of a dB below 0 dB
  localparam lhpmv_gain_t TAIL [0:80] = '{
    10'd186, 10'd191, 10'd196, 10'd201, 10'd206, 10'd211, 10'd216, 10'd221, 10'd226,
    10'd231, 10'd236, 10'd241, 10'd246, 10'd251, 10'd256, 10'd261, 10'd266, 10'd271,
    10'd276, 10'd281, 10'd286, 10'd291, 10'd296, 10'd301, 10'd306, 10'd311, 10'd316,
    10'd321, 10'd326, 10'd331, 10'd336, 10'd341, 10'd346, 10'd351, 10'd357, 10'd361,
    10'd367, 10'd371, 10'd377, 10'd382, 10'd387, 10'd392, 10'd397, 10'd402, 10'd407,
    10'd412, 10'd417, 10'd422, 10'd427, 10'd432, 10'd438, 10'd443, 10'd448, 10'd452,
    10'd458, 10'd462, 10'd467, 10'd474, 10'd479, 10'd482, 10'd487, 10'd493, 10'd500,
    10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527, 10'd537, 10'd542, 10'd553,
    10'd567, 10'd583, 10'd602, 10'd627, 10'd643, 10'd662, 10'd687, 10'd722, 10'd783
  };

  lhpmv_code_t tail_idx;

  always_comb begin
    tail_idx = code - LHPMV_LINEAR_LAST - 7'h01;
    mute = (code >= LHPMV_MUTE_FIRST);
    if (code <= LHPMV_LINEAR_LAST) begin
      atten_tenths = lhpmv_gain_t'({3'h0, code} * LHPMV_STEP_TENTHS);
    end else if (mute) begin
      // muted paths report the deepest real step so the gain never looks louder
      atten_tenths = TAIL[80];
    end else begin
      atten_tenths = TAIL[tail_idx];
    end
  end

endmodule : lhpmv_gain_decode

`default_nettype wire

// ==== design/lhpmv_pkg.sv ====
// constants and types for the left headphone mix volume register bank
package lhpmv_pkg;

  typedef logic [7:0] lhpmv_addr_t;
  typedef logic [7:0] lhpmv_byte_t;
  typedef logic [6:0] lhpmv_code_t;
  typedef logic [9:0] lhpmv_gain_t;

  localparam int LHPMV_NUM_SRC = 5;

  localparam lhpmv_addr_t LHPMV_OFS_LEFT_LINE_B = 8'h2d;
  localparam lhpmv_addr_t LHPMV_OFS_LEFT_AMP = 8'h2e;
  localparam lhpmv_addr_t LHPMV_OFS_LEFT_DAC = 8'h2f;
  localparam lhpmv_addr_t LHPMV_OFS_RIGHT_LINE_B = 8'h30;
  localparam lhpmv_addr_t LHPMV_OFS_RIGHT_AMP = 8'h31;

  localparam int LHPMV_ROUTE_BIT = 7;
  localparam int LHPMV_CODE_MSB = 6;
  localparam int LHPMV_CODE_LSB = 0;

  localparam lhpmv_byte_t LHPMV_RESET_VALUE = 8'h00;
  localparam lhpmv_gain_t LHPMV_GAIN_RESET = 10'h000;

  // first code of the mute range, and last code of the even 0.5 dB stretch
  localparam lhpmv_code_t LHPMV_MUTE_FIRST = 7'h76;
  localparam lhpmv_code_t LHPMV_LINEAR_LAST = 7'h24;
  localparam lhpmv_gain_t LHPMV_STEP_TENTHS = 10'h005;

endpackage : lhpmv_pkg

// ==== design/lhpmv_regs.sv ====
// source-to-left-headphone route and volume register bank
`timescale 1ns/1ps
`default_nettype none

module lhpmv_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port from the serial control interface
  input wire lhpmv_pkg::lhpmv_addr_t reg_addr,
  input wire logic reg_wr_en,
  input wire lhpmv_pkg::lhpmv_byte_t reg_wr_data,
  input wire logic reg_rd_en,
  output lhpmv_pkg::lhpmv_byte_t reg_rd_data,
  output logic reg_rd_valid,
  output logic reg_hit,
  // left line input b path
  output logic left_line_input_b_route,
  output lhpmv_pkg::lhpmv_code_t left_line_input_b_code,
  output logic left_line_input_b_mute,
  output lhpmv_pkg::lhpmv_gain_t left_line_input_b_atten,
  // left input amplifier path
  output logic left_input_amplifier_route,
  output lhpmv_pkg::lhpmv_code_t left_input_amplifier_code,
  output logic left_input_amplifier_mute,
  output lhpmv_pkg::lhpmv_gain_t left_input_amplifier_atten,
  // left dac path
  output logic left_dac_path_route,
  output lhpmv_pkg::lhpmv_code_t left_dac_path_code,
  output logic left_dac_path_mute,
  output lhpmv_pkg::lhpmv_gain_t left_dac_path_atten,
  // right line input b path
  output logic right_line_input_b_route,
  output lhpmv_pkg::lhpmv_code_t right_line_input_b_code,
  output logic right_line_input_b_mute,
  output lhpmv_pkg::lhpmv_gain_t right_line_input_b_atten,
  // right input amplifier path
  output logic right_input_amplifier_route,
  output lhpmv_pkg::lhpmv_code_t right_input_amplifier_code,
  output logic right_input_amplifier_mute,
  output lhpmv_pkg::lhpmv_gain_t right_input_amplifier_atten,
  // summary: any source audibly feeding the left headphone output
  output logic left_headphone_output_live
);
  import lhpmv_pkg::*;

  // offset to source index; out of range gives LHPMV_NUM_SRC
  function automatic logic [2:0] src_index(input lhpmv_addr_t addr);
    logic [2:0] idx;
    unique case (addr)
      LHPMV_OFS_LEFT_LINE_B: idx = 3'h0;
      LHPMV_OFS_LEFT_AMP: idx = 3'h1;
      LHPMV_OFS_LEFT_DAC: idx = 3'h2;
      LHPMV_OFS_RIGHT_LINE_B: idx = 3'h3;
      LHPMV_OFS_RIGHT_AMP: idx = 3'h4;
      default: idx = 3'h5;
    endcase
    return idx;
  endfunction : src_index

  function automatic logic is_mapped(input lhpmv_addr_t addr);
    return (src_index(addr) != 3'h5);
  endfunction : is_mapped

  // field extraction, shared by the decoders, the live summary and the outputs
  function automatic logic route_of(input lhpmv_byte_t value);
    return value[LHPMV_ROUTE_BIT];
  endfunction : route_of

  function automatic lhpmv_code_t code_of(input lhpmv_byte_t value);
    return value[LHPMV_CODE_MSB:LHPMV_CODE_LSB];
  endfunction : code_of

  // stored register contents and registered decode of each path
  lhpmv_byte_t vol_reg [LHPMV_NUM_SRC];
  lhpmv_byte_t next_vol_reg [LHPMV_NUM_SRC];
  lhpmv_gain_t atten [LHPMV_NUM_SRC];
  lhpmv_gain_t next_atten [LHPMV_NUM_SRC];
  logic [LHPMV_NUM_SRC-1:0] mute;
  logic [LHPMV_NUM_SRC-1:0] next_mute;
  logic live;
  logic next_live;

  // read side
  lhpmv_byte_t rd_data;
  lhpmv_byte_t next_rd_data;
  logic rd_valid;
  logic next_rd_valid;
  logic hit;
  logic next_hit;

  logic [2:0] sel;
  logic [LHPMV_NUM_SRC-1:0] dec_mute;
  lhpmv_gain_t dec_atten [LHPMV_NUM_SRC];

  // the decoders look at the value about to be stored, so the registered
  // gain and mute change on the same edge as the code itself
  genvar gi;
  generate
    for (gi = 0; gi < LHPMV_NUM_SRC; gi++) begin : g_dec
      lhpmv_gain_decode u_dec (
        .code(code_of(next_vol_reg[gi])),
        .atten_tenths(dec_atten[gi]),
        .mute(dec_mute[gi])
      );
    end
  endgenerate

  // write group: only a mapped write strobe changes a stored byte
  always_comb begin
    sel = src_index(reg_addr);
    for (int i = 0; i < LHPMV_NUM_SRC; i++) begin
      next_vol_reg[i] = vol_reg[i];
    end
    // unmapped writes are dropped; all eight bits are stored as written
    if (reg_wr_en && is_mapped(reg_addr)) begin
      next_vol_reg[sel] = reg_wr_data;
    end
  end

  // decode group, kept apart so the decoders sit between two processes
  // instead of feeding back into the one that drives them
  always_comb begin
    next_live = 1'b0;
    for (int i = 0; i < LHPMV_NUM_SRC; i++) begin
      next_atten[i] = dec_atten[i];
      next_mute[i] = dec_mute[i];
      // a routed but muted path contributes nothing to the mix
      if (route_of(next_vol_reg[i]) && !dec_mute[i]) begin
        next_live = 1'b1;
      end
    end
  end

  // a read returns the value held before any write in the same cycle
  always_comb begin
    next_rd_valid = reg_rd_en;
    next_rd_data = rd_data;
    next_hit = hit;
    if (reg_rd_en) begin
      next_hit = is_mapped(reg_addr);
      if (is_mapped(reg_addr)) begin
        next_rd_data = vol_reg[sel];
      end else begin
        next_rd_data = LHPMV_RESET_VALUE;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < LHPMV_NUM_SRC; i++) begin
        vol_reg[i] <= LHPMV_RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < LHPMV_NUM_SRC; i++) begin
        vol_reg[i] <= next_vol_reg[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < LHPMV_NUM_SRC; i++) begin
        atten[i] <= LHPMV_GAIN_RESET;
      end
      mute <= '0;
      live <= 1'b0;
    end else begin
      for (int i = 0; i < LHPMV_NUM_SRC; i++) begin
        atten[i] <= next_atten[i];
      end
      mute <= next_mute;
      live <= next_live;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= LHPMV_RESET_VALUE;
      rd_valid <= 1'b0;
      hit <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      hit <= next_hit;
    end
  end

  assign reg_rd_data = rd_data;
  assign reg_rd_valid = rd_valid;
  assign reg_hit = hit;
  assign left_headphone_output_live = live;

  // one independent control per source for this driver; other drivers own theirs
  assign left_line_input_b_route = route_of(vol_reg[0]);
  assign left_line_input_b_code = code_of(vol_reg[0]);
  assign left_line_input_b_mute = mute[0];
  assign left_line_input_b_atten = atten[0];

  assign left_input_amplifier_route = route_of(vol_reg[1]);
  assign left_input_amplifier_code = code_of(vol_reg[1]);
  assign left_input_amplifier_mute = mute[1];
  assign left_input_amplifier_atten = atten[1];

  assign left_dac_path_route = route_of(vol_reg[2]);
  assign left_dac_path_code = code_of(vol_reg[2]);
  assign left_dac_path_mute = mute[2];
  assign left_dac_path_atten = atten[2];

  assign right_line_input_b_route = route_of(vol_reg[3]);
  assign right_line_input_b_code = code_of(vol_reg[3]);
  assign right_line_input_b_mute = mute[3];
  assign right_line_input_b_atten = atten[3];

  assign right_input_amplifier_route = route_of(vol_reg[4]);
  assign right_input_amplifier_code = code_of(vol_reg[4]);
  assign right_input_amplifier_mute = mute[4];
  assign right_input_amplifier_atten = atten[4];

endmodule : lhpmv_regs

`default_nettype wire

// ==== sim/lhpmv_regs_asserts.sv ====
// checker for the route and volume register bank
`timescale 1ns/1ps
`default_nettype none
module lhpmv_regs_asserts import lhpmv_pkg::*; (
  // clock, reset and register port
  input wire logic mclk,
  input wire logic resetn,
  input wire lhpmv_addr_t reg_addr,
  input wire logic reg_wr_en,
  input wire lhpmv_byte_t reg_wr_data,
  input wire logic reg_rd_en,
  input wire lhpmv_byte_t reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic reg_hit,
  // left dac path
  input wire logic left_dac_path_route,
  input wire lhpmv_code_t left_dac_path_code,
  input wire logic left_dac_path_mute,
  input wire lhpmv_gain_t left_dac_path_atten
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence dac_wr;
    reg_wr_en && reg_addr == LHPMV_OFS_LEFT_DAC;
  endsequence
  sequence dac_rd;
    reg_rd_en && !reg_wr_en && reg_addr == LHPMV_OFS_LEFT_DAC;
  endsequence
  rd_pulse_a: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid does not follow read strobe");
  route_set_a: assert property (dac_wr ##0 reg_wr_data[7] |=> left_dac_path_route)
    else $error("route bit not set by write");
  route_clr_a: assert property (dac_wr ##0 !reg_wr_data[7] |=> !left_dac_path_route)
    else $error("route bit not cleared by write");
  code_store_a: assert property (dac_wr |=> left_dac_path_code == lhpmv_code_t'($past(reg_wr_data)))
    else $error("code differs from written value");
  code_hold_a: assert property (!reg_wr_en |=> $stable(left_dac_path_code) && $stable(left_dac_path_route))
    else $error("path changed without a write");
  mute_range_a: assert property (left_dac_path_mute == (left_dac_path_code >= LHPMV_MUTE_FIRST))
    else $error("mute does not match code range");
  mute_atten_a: assert property (left_dac_path_mute |-> left_dac_path_atten == 10'h30f)
    else $error("muted path attenuation wrong");
  linear_atten_a: assert property (left_dac_path_code <= LHPMV_LINEAR_LAST |->
    left_dac_path_atten == 10'(left_dac_path_code) * 10'h005)
    else $error("half dB step attenuation wrong");
  read_back_a: assert property (dac_rd |=> reg_hit && reg_rd_data[6:0] == $past(left_dac_path_code) && reg_rd_data[7] == $past(left_dac_path_route))
    else $error("read back differs from stored code");
  unmapped_a: assert property (reg_rd_en &&
    (reg_addr < LHPMV_OFS_LEFT_LINE_B || reg_addr > LHPMV_OFS_RIGHT_AMP) |=>
    !reg_hit && reg_rd_data == LHPMV_RESET_VALUE)
    else $error("unmapped read not zero");
endmodule : lhpmv_regs_asserts
bind lhpmv_regs lhpmv_regs_asserts i_lhpmv_regs_asserts (.mclk(mclk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .reg_hit(reg_hit), .left_dac_path_route(left_dac_path_route),
  .left_dac_path_code(left_dac_path_code), .left_dac_path_mute(left_dac_path_mute),
  .left_dac_path_atten(left_dac_path_atten));
`default_nettype wire

// ==== sim/lhpmv_regs_test.sv ====
// self-checking bench for the route and volume register bank
`timescale 1ns/1ps
`default_nettype none
module lhpmv_regs_test;
  import lhpmv_pkg::*;
  logic mclk = 0, resetn = 0, reg_wr_en = 0, reg_rd_en = 0;
  lhpmv_addr_t reg_addr = 8'h00;
  lhpmv_byte_t reg_wr_data = 8'h00, reg_rd_data;
  logic reg_rd_valid, reg_hit, live;
  wire [4:0] s_route, s_mute;
  wire lhpmv_code_t s_code [5];
  wire lhpmv_gain_t s_atten [5];
  logic exp_live;
  integer seed = 32'h5ddf;
  int num_errors = 0, comparisons = 0;
  logic [8:0] exp_q[$];
  lhpmv_byte_t mem [5] = '{default: 8'h00};
  lhpmv_code_t cd [9] = '{7'h00, 7'h24, 7'h25, 7'h57, 7'h74, 7'h75, 7'h76, 7'h7e, 7'h7f};
  lhpmv_gain_t at [9] = '{10'h000, 10'h0b4, 10'h0ba, 10'h1b6, 10'h2d2, 10'h30f, 10'h30f,
    10'h30f, 10'h30f};
  lhpmv_regs i_lhpmv_regs (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit),
    .left_line_input_b_route(s_route[0]), .left_line_input_b_code(s_code[0]),
    .left_line_input_b_mute(s_mute[0]), .left_line_input_b_atten(s_atten[0]),
    .left_input_amplifier_route(s_route[1]), .left_input_amplifier_code(s_code[1]),
    .left_input_amplifier_mute(s_mute[1]), .left_input_amplifier_atten(s_atten[1]),
    .left_dac_path_route(s_route[2]), .left_dac_path_code(s_code[2]),
    .left_dac_path_mute(s_mute[2]), .left_dac_path_atten(s_atten[2]),
    .right_line_input_b_route(s_route[3]), .right_line_input_b_code(s_code[3]),
    .right_line_input_b_mute(s_mute[3]), .right_line_input_b_atten(s_atten[3]),
    .right_input_amplifier_route(s_route[4]), .right_input_amplifier_code(s_code[4]),
    .right_input_amplifier_mute(s_mute[4]), .right_input_amplifier_atten(s_atten[4]),
    .left_headphone_output_live(live));
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // every source path against the byte last written to it; atten only where it is known
  task automatic chk_paths(input logic zero_atten);
    exp_live = 1'b0;
    for (int i = 0; i < 5; i++) begin
      chk("route", 10'(s_route[i]), 10'(mem[i][7]));
      chk("code", 10'(s_code[i]), 10'(mem[i][6:0]));
      chk("mute", 10'(s_mute[i]), 10'(mem[i][6:0] >= LHPMV_MUTE_FIRST));
      if (zero_atten) chk("atten", s_atten[i], 10'h000);
      exp_live = exp_live | (mem[i][7] & (mem[i][6:0] < LHPMV_MUTE_FIRST));
    end
    chk("live", 10'(live), 10'(exp_live));
  endtask : chk_paths
  // one bus cycle; strobes stay as set until the next call, so no double assignment
  task automatic op(input logic w, input logic r, input lhpmv_addr_t a, input lhpmv_byte_t d,
    input logic [8:0] e);
    reg_wr_en = w;
    reg_rd_en = r;
    reg_addr = a;
    reg_wr_data = d;
    if (r) exp_q.push_back(e);
    @(posedge mclk);
    #2;
  endtask : op
  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("Error read expected none seen %h", reg_rd_data);
      end
      else chk("read", {1'b0, reg_hit, reg_rd_data}, {1'b0, exp_q.pop_front()});
    end
  end
  initial begin
    #1000000;
    num_errors++;
    $display("Error timeout expected finish seen hang");
    close_out();
  end
  initial begin
    repeat (6) @(posedge mclk);
    #2;
    resetn = 1;
    for (int i = 0; i < 5; i++) op(0, 1, LHPMV_OFS_LEFT_LINE_B + 8'(i), 0, 9'h100);
    chk_paths(1'b1);
    for (int i = 0; i < 5; i++) begin
      mem[i] = 8'($random(seed));
      op(1, 0, LHPMV_OFS_LEFT_LINE_B + 8'(i), mem[i], 0);
    end
    op(1, 0, 8'h32, 8'hff, 0);
    chk_paths(1'b0);
    for (int i = 0; i < 5; i++) op(0, 1, LHPMV_OFS_LEFT_LINE_B + 8'(i), 0, {1'b1, mem[i]});
    op(0, 1, 8'h2c, 0, 9'h000);
    op(0, 1, 8'h32, 0, 9'h000);
    op(1, 1, 8'h2d, 8'h5a, {1'b1, mem[0]});
    op(0, 1, 8'h2d, 0, 9'h15a);
    op(0, 0, 0, 0, 0);
    // reset in mid-run must wipe every source back to unrouted, 0 dB
    resetn = 0;
    op(0, 0, 0, 0, 0);
    resetn = 1;
    for (int i = 0; i < 5; i++) op(0, 1, LHPMV_OFS_LEFT_LINE_B + 8'(i), 0, 9'h100);
    for (int i = 0; i < 5; i++) mem[i] = 8'h00;
    chk_paths(1'b1);
    for (int i = 0; i < 9; i++) begin
      op(1, 0, LHPMV_OFS_LEFT_DAC, {i[0], cd[i]}, 0);
      chk("route", 10'(s_route[2]), 10'(i[0]));
      chk("code", 10'(s_code[2]), 10'(cd[i]));
      chk("mute", 10'(s_mute[2]), 10'(cd[i] >= LHPMV_MUTE_FIRST));
      chk("atten", s_atten[2], at[i]);
      chk("live", 10'(live), 10'(i[0] && cd[i] < LHPMV_MUTE_FIRST));
      op(0, 1, LHPMV_OFS_LEFT_DAC, 0, {1'b1, i[0], cd[i]});
    end
    op(0, 0, 0, 0, 0);
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge mclk);
    if (exp_q.size() > 0) num_errors++;
    close_out();
  end
endmodule : lhpmv_regs_test
`default_nettype wire
